// [rtl/rfsse_pkg.sv]
// Constants and types shared by the instruction execution block
package rfsse_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_BANK = 8'h10;
  localparam logic [7:0] OFF_IDX_BASE = 8'h14;
  localparam logic [7:0] OFF_MEM_PTR = 8'h18;
  localparam logic [7:0] OFF_MEM_DATA = 8'h1C;
  localparam logic [7:0] OFF_STATE = 8'h20;

  // Status register field positions
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_HALF = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_WRAP = 3;
  localparam int unsigned ST_N = 4;
  localparam int unsigned ST_PWR_DOWN = 5;
  localparam int unsigned ST_EXPIRED = 6;

  // Control and state field positions
  localparam int unsigned CTRL_EXT_EN = 0;
  localparam int unsigned STATE_BUSY = 0;
  localparam int unsigned STATE_ASLEEP = 1;

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h60;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] INSTR_RESET = 16'h0000;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [11:0] ADDR_RESET = 12'h000;

  // Opcode fields, matched on the upper bits of the instruction word; sleep matches the whole word
  localparam logic [5:0] OPC_ROTR = 6'h10;
  localparam logic [5:0] OPC_SUBB = 6'h15;
  localparam logic [6:0] OPC_FILL = 7'h34;
  localparam logic [7:0] OPC_SUBL = 8'h08;
  localparam logic [15:0] OPC_SLEEP = 16'h0003;

  // Bit positions of the destination and bank selectors
  localparam int unsigned BIT_DEST = 9;
  localparam int unsigned BIT_BANK = 8;

  // Addressing constants
  localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [7:0] FILL_VALUE = 8'hFF;
  localparam int unsigned MEM_AW = 12;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_DECODE = 6'b00_0010,
    ST_READ = 6'b00_0100,
    ST_PROC = 6'b00_1000,
    ST_WRITE = 6'b01_0000,
    ST_SLEEP = 6'b10_0000
  } rfsse_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ROTR = 3'h1,
    OP_FILL = 3'h2,
    OP_SLEEP = 3'h3,
    OP_SUBB = 3'h4,
    OP_SUBL = 3'h5
  } rfsse_op_t;
endpackage : rfsse_pkg

// [rtl/rfsse_mem.sv]
// Banked data register file: one write port, one registered read port
`timescale 1ns/1ns
module rfsse_mem
  import rfsse_pkg::*;
(
  input wire logic pclk,
  input wire logic we,
  input wire logic [MEM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [MEM_AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1 << MEM_AW)-1];

  // No reset: contents are undefined until written, like real file registers
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : rfsse_mem

// [rtl/rfsse_core.sv]
// Execution block for rotate, fill, sleep and two subtract instructions
//
// Operation
// - The plain rotate right moves each bit of the operand one place down and bit 0 to bit 7.
// - The plain rotate right changes only the negative and zero flags.
// - Destination bit 0 sends the result to the accumulator, 1 sends it to the register.
// - Bank bit 0 picks the access bank, bank bit 1 lets the bank select register choose.
// - With the extended set on and bank bit 0, operands up to 5Fh use indexed literal offset.
// - The fill opcode writes FFh to the addressed register and leaves all flags alone.
// - Sleep clears the watchdog and its postscaler and halts the oscillator in phase four.
// - Sleep sets the watchdog expiry bit and clears the power-down bit, nothing else.
// - A wake-up caused by the watchdog clears the watchdog expiry bit.
// - Subtract with borrow computes accumulator minus register minus inverted carry.
// - Subtract with borrow stores per destination bit and updates all five arithmetic flags.
// - Literal subtract computes literal minus accumulator into the accumulator with flags.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
module rfsse_core
  import rfsse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_wdt,
  input wire logic wake_ext,
  output logic sleep_active,
  output logic osc_run,
  output logic wdt_clear
);
  typedef struct packed {
    rfsse_state_t st;
    rfsse_op_t op;
    logic [15:0] instr;
    logic ext_en;
    logic [7:0] acc;
    logic [7:0] status;
    logic [3:0] bank;
    logic [11:0] idx_base;
    logic [11:0] mem_ptr;
    logic [7:0] opnd;
    logic [7:0] res;
    logic [7:0] new_status;
    logic [2:0] wwdt_sync;
    logic [2:0] wext_sync;
    logic wwdt_lvl;
    logic wext_lvl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wdt_clear;
    logic osc_run;
    logic sleep_active;
  } rfsse_regs_t;

  localparam rfsse_regs_t REGS_RESET = '{
    st: ST_IDLE,
    op: OP_NONE,
    instr: INSTR_RESET,
    ext_en: 1'b0,
    acc: ACC_RESET,
    status: STATUS_RESET,
    bank: BANK_RESET,
    idx_base: ADDR_RESET,
    mem_ptr: ADDR_RESET,
    opnd: 8'h00,
    res: 8'h00,
    new_status: STATUS_RESET,
    wwdt_sync: 3'h0,
    wext_sync: 3'h0,
    wwdt_lvl: 1'b0,
    wext_lvl: 1'b0,
    prdata: 32'h0000_0000,
    pready: 1'b0,
    pslverr: 1'b0,
    wdt_clear: 1'b0,
    osc_run: 1'b1,
    sleep_active: 1'b0
  };

  rfsse_regs_t r_q;
  rfsse_regs_t r_d;

  logic mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [MEM_AW-1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [MEM_AW-1:0] op_addr;
  logic dest_reg;
  logic apb_idle;
  logic apb_commit;

  rfsse_mem u_mem (
    .pclk(pclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // Operand address from the file field of the held instruction word
  always_comb
  begin
    logic [7:0] f;
    f = r_q.instr[7:0];
    if (r_q.instr[BIT_BANK])
    begin
      op_addr = {r_q.bank, f};
    end
    else if (r_q.ext_en && (f <= ACCESS_SPLIT))
    begin
      // Offset wraps within the file rather than faulting
      op_addr = r_q.idx_base + {4'h0, f};
    end
    else if (f <= ACCESS_SPLIT)
    begin
      op_addr = {ACCESS_LO_BANK, f};
    end
    else
    begin
      op_addr = {ACCESS_HI_BANK, f};
    end
  end

  // Fill always lands in the register, literal subtract in the accumulator; rotate and subtract with borrow follow the destination bit
  assign dest_reg = (r_q.op == OP_FILL)
    || (((r_q.op == OP_ROTR) || (r_q.op == OP_SUBB)) && r_q.instr[BIT_DEST]);

  // Bus answers only between instructions, so software never races the core
  assign apb_idle = (r_q.st == ST_IDLE) || (r_q.st == ST_SLEEP);
  assign apb_commit = psel && penable && r_q.pready;

  assign mem_we = ((r_q.st == ST_WRITE) && dest_reg)
    || (apb_commit && pwrite && (paddr == OFF_MEM_DATA));
  assign mem_waddr = (r_q.st == ST_WRITE) ? op_addr : r_q.mem_ptr;
  assign mem_wdata = (r_q.st == ST_WRITE) ? r_q.res : pwdata[7:0];
  assign mem_raddr = apb_idle ? r_q.mem_ptr : op_addr;

  always_comb
  begin
    logic [7:0] sa;
    logic [7:0] sb;
    logic bin;
    logic [8:0] diff;
    logic [4:0] hdiff;
    logic [7:0] st;
    sa = 8'h00;
    sb = 8'h00;
    bin = 1'b0;
    diff = 9'h000;
    hdiff = 5'h00;
    st = r_q.status;
    r_d = r_q;
    r_d.wdt_clear = 1'b0;
    // Ready is a one-cycle pulse even if a master abandons the access
    r_d.pready = 1'b0;

    // Wake pins: first stage feeds only the second; a level counts once stages 2 and 3 agree
    r_d.wwdt_sync = {r_q.wwdt_sync[1:0], wake_wdt};
    r_d.wext_sync = {r_q.wext_sync[1:0], wake_ext};
    if (r_q.wwdt_sync[1] == r_q.wwdt_sync[2]) r_d.wwdt_lvl = r_q.wwdt_sync[2];
    if (r_q.wext_sync[1] == r_q.wext_sync[2]) r_d.wext_lvl = r_q.wext_sync[2];

    unique case (r_q.st)
      ST_IDLE: r_d.st = ST_IDLE;
      ST_DECODE:
      begin
        // Operand address is on the file's read port during this phase; patterns are disjoint
        r_d.op = OP_NONE;
        if (r_q.instr[15:10] == OPC_ROTR) r_d.op = OP_ROTR;
        if (r_q.instr[15:10] == OPC_SUBB) r_d.op = OP_SUBB;
        if (r_q.instr[15:9] == OPC_FILL) r_d.op = OP_FILL;
        if (r_q.instr[15:8] == OPC_SUBL) r_d.op = OP_SUBL;
        if (r_q.instr == OPC_SLEEP) r_d.op = OP_SLEEP;
        r_d.st = ST_READ;
      end
      ST_READ:
      begin
        r_d.opnd = (r_q.op == OP_SUBL) ? r_q.instr[7:0] : mem_rdata;
        r_d.st = ST_PROC;
      end
      ST_PROC:
      begin
        unique case (r_q.op)
          OP_ROTR:
          begin
            r_d.res = {r_q.opnd[0], r_q.opnd[7:1]};
            st[ST_N] = r_q.opnd[0];
            st[ST_Z] = (r_q.opnd == 8'h00);
          end
          OP_FILL:
          begin
            r_d.res = FILL_VALUE;
          end
          OP_SUBB, OP_SUBL:
          begin
            if (r_q.op == OP_SUBB)
            begin
              sa = r_q.acc;
              sb = r_q.opnd;
              bin = ~r_q.status[ST_C];
            end
            else
            begin
              sa = r_q.opnd;
              sb = r_q.acc;
            end
            diff = {1'b0, sa} - {1'b0, sb} - {8'h00, bin};
            hdiff = {1'b0, sa[3:0]} - {1'b0, sb[3:0]} - {4'h0, bin};
            r_d.res = diff[7:0];
            st[ST_C] = ~diff[8];
            st[ST_HALF] = ~hdiff[4];
            st[ST_WRAP] = (sa[7] != sb[7]) && (diff[7] != sa[7]);
            st[ST_N] = diff[7];
            st[ST_Z] = (diff[7:0] == 8'h00);
          end
          OP_SLEEP:
          begin
            st[ST_EXPIRED] = 1'b1;
            st[ST_PWR_DOWN] = 1'b0;
          end
          default: r_d.res = r_q.opnd;
        endcase
        r_d.new_status = st;
        r_d.st = ST_WRITE;
      end
      ST_WRITE:
      begin
        r_d.status = r_q.new_status;
        if ((((r_q.op == OP_ROTR) || (r_q.op == OP_SUBB)) && !dest_reg) || (r_q.op == OP_SUBL))
        begin
          r_d.acc = r_q.res;
        end
        if (r_q.op == OP_SLEEP)
        begin
          // Watchdog and postscaler clear as one pulse in the same cycle that osc_run drops
          r_d.wdt_clear = 1'b1;
          r_d.osc_run = 1'b0;
          r_d.st = ST_SLEEP;
        end
        else
        begin
          r_d.st = ST_IDLE;
        end
      end
      ST_SLEEP:
      begin
        // A wake level still high when sleep executes wakes the core at once
        if (r_q.wwdt_lvl) r_d.status[ST_EXPIRED] = 1'b0;
        if (r_q.wwdt_lvl || r_q.wext_lvl)
        begin
          r_d.osc_run = 1'b1;
          r_d.st = ST_IDLE;
        end
      end
    endcase

    // APB: one wait state, write takes effect at the edge that sees pready high
    if (apb_commit)
    begin
      r_d.pslverr = 1'b0;
      if (pwrite && !r_q.pslverr)
      begin
        unique case (paddr)
          OFF_CTRL: r_d.ext_en = pwdata[CTRL_EXT_EN];
          OFF_INSTR:
          begin
            // Instruction writes during sleep are dropped
            if (r_q.st == ST_IDLE)
            begin
              r_d.instr = pwdata[15:0];
              r_d.st = ST_DECODE;
            end
          end
          OFF_ACC: r_d.acc = pwdata[7:0];
          OFF_STATUS: r_d.status = pwdata[7:0];
          OFF_BANK: r_d.bank = pwdata[3:0];
          OFF_IDX_BASE: r_d.idx_base = pwdata[11:0];
          OFF_MEM_PTR: r_d.mem_ptr = pwdata[11:0];
          default:
          begin
          end
        endcase
      end
    end
    else if (psel && penable && apb_idle)
    begin
      r_d.pready = 1'b1;
      r_d.pslverr = 1'b0;
      r_d.prdata = 32'h0000_0000;
      unique case (paddr)
        OFF_CTRL: r_d.prdata[CTRL_EXT_EN] = r_q.ext_en;
        OFF_INSTR: r_d.prdata[15:0] = r_q.instr;
        OFF_ACC: r_d.prdata[7:0] = r_q.acc;
        OFF_STATUS: r_d.prdata[7:0] = r_q.status;
        OFF_BANK: r_d.prdata[3:0] = r_q.bank;
        OFF_IDX_BASE: r_d.prdata[11:0] = r_q.idx_base;
        OFF_MEM_PTR: r_d.prdata[11:0] = r_q.mem_ptr;
        OFF_MEM_DATA: r_d.prdata[7:0] = mem_rdata;
        OFF_STATE:
        begin
          r_d.prdata[STATE_BUSY] = (r_q.st != ST_IDLE) && (r_q.st != ST_SLEEP);
          r_d.prdata[STATE_ASLEEP] = (r_q.st == ST_SLEEP);
        end
        default: r_d.pslverr = 1'b1;
      endcase
    end
    r_d.sleep_active = ~r_d.osc_run;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_q <= REGS_RESET;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign sleep_active = r_q.sleep_active;
  assign osc_run = r_q.osc_run;
  assign wdt_clear = r_q.wdt_clear;
endmodule : rfsse_core

// [verif/rfsse_core_properties.sv]
// Port-level checks for the execution block
`timescale 1ns/1ns
module rfsse_core_properties
  import rfsse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wake_wdt,
  input wire logic wake_ext,
  input wire logic sleep_active,
  input wire logic osc_run,
  input wire logic wdt_clear
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic sleep_wr;
  assign sleep_wr = psel && penable && pready && pwrite && paddr == OFF_INSTR
    && pwdata[15:0] == OPC_SLEEP;
  property p_sleep_osc;
    sleep_active |-> !osc_run && (wdt_clear == $rose(sleep_active));
  endproperty
  a_sleep_osc: assert property (p_sleep_osc) else $error("sleep flag mismatch");
  property p_wdt_pulse;
    wdt_clear |=> !wdt_clear;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("long clear pulse");
  property p_osc_stop;
    $fell(osc_run) |-> wdt_clear;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("stop without clear");
  // Four phases after the accepting edge, then the registered pulse
  property p_sleep_time;
    wdt_clear |-> $past(sleep_wr, 5);
  endproperty
  a_sleep_time: assert property (p_sleep_time) else $error("sleep timing");
  property p_wake_cause;
    $rose(osc_run) |-> $past(wake_wdt, 3) || $past(wake_ext, 3);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake w/o cause");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
  property p_ready_req;
    pready |-> psel && penable;
  endproperty
  a_ready_req: assert property (p_ready_req) else $error("ready w/o access");
  property p_err_map;
    pready |-> pslverr == (paddr > OFF_STATE || paddr[1:0] != 2'b00);
  endproperty
  a_err_map: assert property (p_err_map) else $error("error decode");
  c_sleep: cover property ($fell(osc_run));
  c_wake: cover property ($rose(osc_run));
  c_err: cover property (pready && pslverr);
endmodule : rfsse_core_properties

// [verif/rfsse_wake_src.sv]
// Wake sources: watchdog and external pins held high for a few cycles
`timescale 1ns/1ns
module rfsse_wake_src #(
  parameter int HOLD = 6
)
(
  input wire logic pclk,
  input wire logic req_wdt,
  input wire logic req_ext,
  output logic wake_wdt,
  output logic wake_ext
);
  int cw = 0;
  int ce = 0;
  initial wake_wdt = 1'b0;
  initial wake_ext = 1'b0;
  // Levels drop again so a second sleep is not cut short
  always @(posedge pclk)
  begin
    cw <= req_wdt ? HOLD : (cw > 0 ? cw - 1 : 0);
    ce <= req_ext ? HOLD : (ce > 0 ? ce - 1 : 0);
    wake_wdt <= req_wdt || cw > 1;
    wake_ext <= req_ext || ce > 1;
  end
endmodule : rfsse_wake_src

// [verif/rfsse_core_tb.sv]
// Self-checking bench for the execution block
`timescale 1ns/1ns
module rfsse_core_tb;
  import rfsse_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r;
  logic rerr;
  logic pready, pslverr, wake_wdt, wake_ext, sleep_active, osc_run, wdt_clear;
  logic req_wdt = 1'b0;
  logic req_ext = 1'b0;
  int error_cnt = 0;
  int n_compared = 0;
  int clr_cnt = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    if (wdt_clear === 1'b1) clr_cnt++;
  end
  rfsse_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_wdt(wake_wdt), .wake_ext(wake_ext),
    .sleep_active(sleep_active), .osc_run(osc_run), .wdt_clear(wdt_clear));
  rfsse_wake_src wsrc (.pclk(pclk), .req_wdt(req_wdt), .req_ext(req_ext),
    .wake_wdt(wake_wdt), .wake_ext(wake_ext));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 60);
    r = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 60) chk(32'h0000_0000, 32'h0000_0001);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, e);
  endtask : rc
  task automatic mem_w(input logic [11:0] a, input logic [7:0] v);
    wr(OFF_MEM_PTR, {20'h0_0000, a});
    wr(OFF_MEM_DATA, {24'h00_0000, v});
  endtask : mem_w
  task automatic mem_rc(input logic [11:0] a, input logic [7:0] e);
    wr(OFF_MEM_PTR, {20'h0_0000, a});
    rc(OFF_MEM_DATA, {24'h00_0000, e});
  endtask : mem_rc
  task automatic wt(input logic s);
    int n;
    n = 0;
    while (sleep_active !== s && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0000_0000, sleep_active}, {31'h0000_0000, s});
    chk({31'h0000_0000, osc_run}, {31'h0000_0000, ~s});
  endtask : wt
  task automatic t_rot;
    mem_w(12'h005, 8'hD7);
    wr(OFF_STATUS, 32'h0000_006F);
    wr(OFF_INSTR, 32'h0000_4205);
    mem_rc(12'h005, 8'hEB);
    rc(OFF_STATUS, 32'h0000_007B);
    wr(OFF_BANK, 32'h0000_0003);
    mem_w(12'h380, 8'h01);
    wr(OFF_INSTR, 32'h0000_4180);
    rc(OFF_ACC, 32'h0000_0080);
    mem_rc(12'h380, 8'h01);
  endtask : t_rot
  task automatic t_fill;
    mem_w(12'h010, 8'h5A);
    wr(OFF_CTRL, 32'h0000_0001);
    wr(OFF_IDX_BASE, 32'h0000_0200);
    wr(OFF_STATUS, 32'h0000_0075);
    wr(OFF_INSTR, 32'h0000_6810);
    wr(OFF_INSTR, 32'h0000_6860);
    mem_rc(12'h210, 8'hFF);
    mem_rc(12'h010, 8'h5A);
    mem_rc(12'hF60, 8'hFF);
    rc(OFF_STATUS, 32'h0000_0075);
    wr(OFF_CTRL, 32'h0000_0000);
  endtask : t_fill
  task automatic t_subb;
    wr(OFF_ACC, 32'h0000_0005);
    mem_w(12'h007, 8'h02);
    wr(OFF_STATUS, 32'h0000_0060);
    wr(OFF_INSTR, 32'h0000_5407);
    rc(OFF_ACC, 32'h0000_0002);
    rc(OFF_STATUS, 32'h0000_0063);
    mem_w(12'h007, 8'h03);
    wr(OFF_STATUS, 32'h0000_0061);
    wr(OFF_INSTR, 32'h0000_5607);
    mem_rc(12'h007, 8'hFF);
    rc(OFF_STATUS, 32'h0000_0070);
  endtask : t_subb
  task automatic t_subl;
    logic [7:0] w [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
    logic [7:0] k [4] = '{8'h02, 8'h02, 8'h02, 8'h80};
    logic [7:0] q [4] = '{8'h01, 8'h00, 8'hFF, 8'h7F};
    logic [7:0] f [4] = '{8'h63, 8'h67, 8'h70, 8'h69};
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_ACC, {24'h00_0000, w[i]});
      wr(OFF_STATUS, 32'h0000_0060);
      wr(OFF_INSTR, {16'h0000, 8'h08, k[i]});
      rc(OFF_ACC, {24'h00_0000, q[i]});
      rc(OFF_STATUS, {24'h00_0000, f[i]});
    end
  endtask : t_subl
  task automatic t_sleep;
    wr(OFF_STATUS, 32'h0000_003F);
    wr(OFF_INSTR, 32'h0000_0003);
    wt(1'b1);
    rc(OFF_STATE, 32'h0000_0002);
    chk({31'h0000_0000, rerr}, 32'h0000_0000);
    rc(OFF_STATUS, 32'h0000_005F);
    wr(OFF_INSTR, 32'h0000_0855);
    rc(OFF_ACC, 32'h0000_007F);
    req_ext <= 1'b1;
    @(posedge pclk);
    req_ext <= 1'b0;
    wt(1'b0);
    rc(OFF_STATUS, 32'h0000_005F);
    repeat (8) @(posedge pclk);
    wr(OFF_INSTR, 32'h0000_0003);
    wt(1'b1);
    req_wdt <= 1'b1;
    @(posedge pclk);
    req_wdt <= 1'b0;
    wt(1'b0);
    rc(OFF_STATUS, 32'h0000_001F);
    rc(8'h40, 32'h0000_0000);
    chk({31'h0000_0000, rerr}, 32'h0000_0001);
    chk(clr_cnt, 32'h0000_0002);
  endtask : t_sleep
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_rot();
    t_fill();
    t_subb();
    t_subl();
    t_sleep();
    tally_and_finish();
  end
  // Whole run needs well under two thousand cycles
  initial
  begin
    #(100 * 20000);
    error_cnt++;
    tally_and_finish();
  end
endmodule : rfsse_core_tb
bind rfsse_core rfsse_core_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .wake_wdt(wake_wdt), .wake_ext(wake_ext),
  .sleep_active(sleep_active), .osc_run(osc_run), .wdt_clear(wdt_clear));
